// ===== flash_ctrl_pkg.sv
// Constants, types and address map of the flash program/erase control block.
// Assumes a 100 MHz system clock and a byte-wide register port.
package flash_ctrl_pkg;
  localparam logic [15:0] FLASH_CONTROL_ADDR = 16'hfe08;
  localparam logic [15:0] PROTECT_BOUNDARY_ADDR = 16'hffcf;
  localparam logic [15:0] USER_BASE = 16'hdc00;
  localparam logic [15:0] USER_LAST = 16'hfbff;
  localparam logic [15:0] VECT_BASE = 16'hffdc;
  localparam int USER_BYTES = 8192;
  localparam int VECT_BYTES = 36;
  localparam int PAGE_BYTES = 64;
  localparam int ARRAY_BYTES = USER_BYTES + VECT_BYTES;
  localparam int IDX_W = 14;
  localparam int PROG_BIT = 0;
  localparam int ERASE_BIT = 1;
  localparam int MASS_BIT = 2;
  localparam int HV_BIT = 3;
  localparam logic [7:0] FLASH_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PROTECT_BOUNDARY_RESET = 8'hff;
  localparam logic [7:0] PROTECT_ALL_LIMIT = 8'h70;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] BLOCKED_READ = 8'h00;
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_NVS_NS = 10000;
  localparam int NVS_CYCLES = (T_NVS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NVS_W = 11;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } busReq_t;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_SELECTED,
    SEQ_LATCH,
    SEQ_SETTLE,
    SEQ_READY
  } seqState_t;
endpackage

// ===== flash_program_erase_control.sv
// Flash program/erase control: control register, interlock, sequence checker,
// block protection, erase sweep and the flash array itself.
// Assumes a master that issues one-cycle read or write strobes, never both.
// Notes on behaviour
// - High voltage enable sets only with a select and the full sequence followed.
// - High voltage enable drives charge pump on and high voltage to array.
// - Whole-array bit picks mass erase when set, page erase when clear.
// - Erase and program selects can never both be one nor set together.
// - Erase select is read/write; one selects erase.
// - Program select is read/write; one selects program.
// - Erased bits read one; programming can only clear bits to zero.
// - Page erase removes exactly one 64-byte page.
// - Array holds 8192 user bytes plus 36 vector bytes at the top.
// - Array contents are hidden from external viewing.
// - High voltage refused when the target lies in a protected range.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module flash_program_erase_control
  import flash_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire busReq_t busReq,
  input wire logic externalView,
  output logic [7:0] readData,
  output logic chargePumpOn,
  output logic highVoltageArray,
  output logic eraseActive
);


  function automatic logic isUser(input logic [15:0] a);
    return (a >= USER_BASE) && (a <= USER_LAST);
  endfunction

  function automatic logic isArray(input logic [15:0] a);
    return isUser(a) || (a >= VECT_BASE);
  endfunction

  // Vector block sits just above the user bytes in the index space
  function automatic logic [IDX_W-1:0] arrayIdx(input logic [15:0] a);
    logic [15:0] off;
    off = isUser(a) ? a - USER_BASE : a - VECT_BASE + 16'(USER_BYTES);
    return off[IDX_W-1:0];
  endfunction

  // Protected range runs from the boundary page up to the top of the map
  function automatic logic isProtected(input logic [15:0] a, input logic [7:0] b);
    return (b != PROTECT_BOUNDARY_RESET) && ((b <= PROTECT_ALL_LIMIT) || (a >= {2'b11, b, 6'h00}));
  endfunction


  logic [7:0] mem [ARRAY_BYTES];
  logic prog_q, erase_q, mass_q, hv_q;
  logic prog_d, erase_d, mass_d, hv_d;
  logic [7:0] bpr_q;
  seqState_t seq_q, seq_d;
  logic [NVS_W-1:0] nvsCnt_q;
  logic [15:0] target_q;
  logic sweeping_q;
  logic [IDX_W-1:0] sweepIdx_q, sweepEnd_q;
  logic [7:0] readData_q;
  logic pumpOn_q, hvArray_q;

  wire ctrlHit = busReq.addr == FLASH_CONTROL_ADDR;
  wire bprHit = busReq.addr == PROTECT_BOUNDARY_ADDR;
  wire arrayHit = isArray(busReq.addr);
  wire ctrlWrite = busReq.wr && ctrlHit;
  wire arrayWrite = busReq.wr && arrayHit;
  wire [IDX_W-1:0] busIdx = arrayIdx(busReq.addr);
  wire wProg = busReq.wdata[PROG_BIT];
  wire wErase = busReq.wdata[ERASE_BIT];
  wire wHv = busReq.wdata[HV_BIT];

  wire [IDX_W-1:0] targetIdx = arrayIdx(target_q);
  wire targetVect = !isUser(target_q);
  // Mass erase touches every byte, so any protected block refuses it
  wire targetProt = erase_q && mass_q ? (bpr_q != PROTECT_BOUNDARY_RESET)
                                      : isProtected(target_q, bpr_q);
  // Vector page holds the security bytes; only mass erase may clear it
  wire vectRefused = erase_q && !mass_q && targetVect;
  wire hvAllowed = (prog_q || erase_q) && (seq_q == SEQ_READY) && !targetProt && !vectRefused;
  wire hvSetting = ctrlWrite && wHv && !hv_q && hvAllowed;
  wire sweepStart = hvSetting && erase_q;

  wire [IDX_W-1:0] pageBase = targetIdx & ~IDX_W'(PAGE_BYTES - 1);
  wire [IDX_W-1:0] sweepLast = mass_q ? IDX_W'(ARRAY_BYTES - 1)
                                      : pageBase + IDX_W'(PAGE_BYTES - 1);
  wire sweepDone = sweeping_q && ((sweepIdx_q == sweepEnd_q) || !hv_q);
  wire progWrite = arrayWrite && hv_q && prog_q && !isProtected(busReq.addr, bpr_q);

  wire [7:0] arrayRead = externalView ? BLOCKED_READ : mem[busIdx];
  wire [7:0] ctrlRead = {4'h0, hv_q, mass_q, erase_q, prog_q};
  wire [7:0] readMux = ctrlHit ? ctrlRead : bprHit ? bpr_q : arrayHit ? arrayRead : 8'h00;

  // Both set in one write leaves both as they were; the other must be clear first
  always_comb begin
    prog_d = prog_q;
    erase_d = erase_q;
    mass_d = mass_q;
    hv_d = hv_q;
    if (ctrlWrite) begin
      mass_d = busReq.wdata[MASS_BIT];
      if (!(wProg && wErase)) begin
        prog_d = wProg && !erase_q;
        erase_d = wErase && !prog_q;
      end
      hv_d = wHv && (hv_q || hvAllowed);
    end
  end


  // A boundary read before a select is made does not count as a step
  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      SEQ_IDLE: if (prog_q || erase_q) seq_d = SEQ_SELECTED;
      SEQ_SELECTED: if (busReq.rd && bprHit) seq_d = SEQ_LATCH;
      SEQ_LATCH: if (arrayWrite) seq_d = SEQ_SETTLE;
      SEQ_SETTLE: if (nvsCnt_q == NVS_W'(NVS_CYCLES - 1)) seq_d = SEQ_READY;
      SEQ_READY: seq_d = SEQ_READY;
      default: seq_d = SEQ_IDLE;
    endcase
    if (!prog_q && !erase_q) seq_d = SEQ_IDLE;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prog_q <= 1'b0;
      erase_q <= 1'b0;
      mass_q <= 1'b0;
      hv_q <= 1'b0;
      seq_q <= SEQ_IDLE;
    end else begin
      prog_q <= prog_d;
      erase_q <= erase_d;
      mass_q <= mass_d;
      hv_q <= hv_d;
      seq_q <= seq_d;
    end
  end


  always_ff @(posedge clk) begin
    if (!rst_b || seq_q != SEQ_SETTLE) begin
      nvsCnt_q <= '0;
    end else begin
      nvsCnt_q <= nvsCnt_q + NVS_W'(1);
    end
  end


  // Boundary is one-time: once narrowed from all-ones it no longer accepts writes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bpr_q <= PROTECT_BOUNDARY_RESET;
      target_q <= USER_BASE;
    end else begin
      if (busReq.wr && bprHit && bpr_q == PROTECT_BOUNDARY_RESET) bpr_q <= busReq.wdata;
      if (seq_q == SEQ_LATCH && arrayWrite) target_q <= busReq.addr;
    end
  end


  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sweeping_q <= 1'b0;
      sweepIdx_q <= '0;
      sweepEnd_q <= '0;
    end else if (sweepStart) begin
      sweeping_q <= 1'b1;
      sweepIdx_q <= mass_q ? '0 : pageBase;
      sweepEnd_q <= sweepLast;
    end else if (sweepDone) begin
      sweeping_q <= 1'b0;
    end else if (sweeping_q) begin
      sweepIdx_q <= sweepIdx_q + IDX_W'(1);
    end
  end


  // One byte per cycle keeps a single write port; mass erase takes about 82 us
  always_ff @(posedge clk) begin
    if (sweeping_q && hv_q) begin
      mem[sweepIdx_q] <= ERASED_BYTE;
    end else if (progWrite) begin
      mem[busIdx] <= mem[busIdx] & busReq.wdata;
    end
  end


  always_ff @(posedge clk) begin
    if (!rst_b) begin
      readData_q <= 8'h00;
      pumpOn_q <= 1'b0;
      hvArray_q <= 1'b0;
    end else begin
      readData_q <= busReq.rd ? readMux : 8'h00;
      pumpOn_q <= hv_d;
      hvArray_q <= hv_d;
    end
  end


  assign readData = readData_q;
  assign chargePumpOn = pumpOn_q;
  assign highVoltageArray = hvArray_q;
  assign eraseActive = sweeping_q;


  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence settleEnds;
    seq_q == SEQ_SETTLE ##1 seq_q == SEQ_READY;
  endsequence

  sequence pageErasing;
    sweepStart && !mass_q ##1 sweeping_q;
  endsequence

  sequence vectPageRequest;
    ctrlWrite && wHv && !hv_q && vectRefused;
  endsequence

  sequence sweepCut;
    sweeping_q && !hv_q && !sweepStart;
  endsequence

  a_select_interlock: assert property (!(prog_q && erase_q))
    else $error("program and erase selects both set");

  a_both_write_kept: assert property (ctrlWrite && wProg && wErase |=> $stable(prog_q) && $stable(erase_q))
    else $error("double select write changed selects");

  a_erase_select_rw: assert property (ctrlWrite && wErase && !wProg && !prog_q |=> erase_q)
    else $error("erase select not stored");

  a_program_select_rw: assert property (ctrlWrite && wProg && !wErase && !erase_q |=> prog_q)
    else $error("program select not stored");

  a_hv_needs_seq: assert property ($rose(hv_q) |-> $past(seq_q) == SEQ_READY && $past(prog_q || erase_q))
    else $error("high voltage set outside sequence");

  a_settle_full_wait: assert property (settleEnds |-> $past(nvsCnt_q, 1) == NVS_W'(NVS_CYCLES - 1))
    else $error("settle wait cut short");

  a_pump_follows_hv: assert property (##1 chargePumpOn == hv_q && highVoltageArray == hv_q)
    else $error("pump output not following enable");

  a_protect_refuses: assert property (ctrlWrite && wHv && !hv_q && targetProt |=> !hv_q)
    else $error("high voltage set on protected target");

  a_mass_scope: assert property (sweepStart && mass_q |=> sweepIdx_q == '0 && sweepEnd_q == IDX_W'(ARRAY_BYTES - 1))
    else $error("mass erase scope wrong");

  a_page_scope: assert property (pageErasing |-> sweepEnd_q - sweepIdx_q == IDX_W'(PAGE_BYTES - 1))
    else $error("page erase scope wrong");

  a_view_blocked: assert property (busReq.rd && arrayHit && externalView |=> readData == BLOCKED_READ)
    else $error("array contents visible externally");

  a_upper_zero: assert property (busReq.rd && ctrlHit |=> readData[7:4] == 4'h0 && readData[3:0] == $past(ctrlRead[3:0]))
    else $error("control read wrong");

  property vectPageKeptOff;
    vectPageRequest |=> !hv_q;
  endproperty

  a_vect_page_refused: assert property (vectPageKeptOff)
    else $error("page erase of vector block allowed");

  property sweepStopsOnHvClear;
    sweepCut |=> !sweeping_q;
  endproperty

  a_sweep_stops_cut: assert property (sweepStopsOnHvClear)
    else $error("erase sweep ran on without high voltage");

  property sweepErases;
    sweeping_q && hv_q |=> mem[$past(sweepIdx_q)] == ERASED_BYTE;
  endproperty

  a_sweep_writes_erased: assert property (sweepErases)
    else $error("erase sweep left a byte unerased");

  property sweepBounded;
    sweeping_q |-> sweepIdx_q <= sweepEnd_q && sweepEnd_q <= IDX_W'(ARRAY_BYTES - 1);
  endproperty

  a_sweep_in_array: assert property (sweepBounded)
    else $error("erase sweep outside array");

  property boundaryLocked;
    busReq.wr && bprHit && bpr_q != PROTECT_BOUNDARY_RESET |=> $stable(bpr_q);
  endproperty

  a_boundary_one_time: assert property (boundaryLocked)
    else $error("narrowed boundary was rewritten");

  property readIdleZero;
    !busReq.rd |=> readData == 8'h00;
  endproperty

  a_read_idle_zero: assert property (readIdleZero)
    else $error("read data present without a read");

endmodule // flash_program_erase_control
`default_nettype wire

// ===== tb_top.sv
// Testbench for the flash program/erase control block: control register, sequence, array.
// Assumes the design's package, a 100 MHz clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import flash_ctrl_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic externalView = 1'b0;
  busReq_t busReq = '0;
  logic [7:0] readData;
  logic chargePumpOn;
  logic highVoltageArray;
  logic eraseActive;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  flash_program_erase_control dut (.clk(clk), .rst_b(rst_b), .busReq(busReq), .externalView(externalView),
    .readData(readData), .chargePumpOn(chargePumpOn), .highVoltageArray(highVoltageArray),
    .eraseActive(eraseActive));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Checks made %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic busWrite(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq <= '0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just after that edge
  task automatic busRead(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq <= '0;
    #1;
    check(readData, exp);
  endtask

  task automatic checkPins(input logic [7:0] exp);
    check({5'h00, chargePumpOn, highVoltageArray, eraseActive}, exp);
  endtask

  // Select, read the boundary, latch a target, settle, then ask for high voltage
  task automatic armHv(input logic [7:0] sel, input logic [15:0] a, input logic [7:0] bpr);
    busWrite(FLASH_CONTROL_ADDR, sel);
    busRead(PROTECT_BOUNDARY_ADDR, bpr);
    busWrite(a, 8'h00);
    repeat (NVS_CYCLES) @(posedge clk);
    busWrite(FLASH_CONTROL_ADDR, sel | 8'h08);
  endtask

  // Bounded wait; a mass sweep is the longest at one byte per cycle
  task automatic waitSweep();
    for (int i = 0; i < 9000 && eraseActive !== 1'b0; i++) begin
      @(posedge clk);
    end
    #1;
    check({7'h00, eraseActive}, 8'h00);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles > 30000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    busRead(FLASH_CONTROL_ADDR, FLASH_CONTROL_RESET);
    @(posedge clk);
    #1;
    check(readData, 8'h00);
    busRead(PROTECT_BOUNDARY_ADDR, PROTECT_BOUNDARY_RESET);
    busRead(16'h0000, 8'h00);
    busWrite(FLASH_CONTROL_ADDR, 8'hff);
    busRead(FLASH_CONTROL_ADDR, 8'h04);
    busWrite(FLASH_CONTROL_ADDR, 8'h01);
    busWrite(FLASH_CONTROL_ADDR, 8'h03);
    busRead(FLASH_CONTROL_ADDR, 8'h01);
    busWrite(FLASH_CONTROL_ADDR, 8'h00);
    busWrite(FLASH_CONTROL_ADDR, 8'h02);
    busWrite(FLASH_CONTROL_ADDR, 8'h03);
    busRead(FLASH_CONTROL_ADDR, 8'h02);
    busWrite(FLASH_CONTROL_ADDR, 8'h0a);
    busRead(FLASH_CONTROL_ADDR, 8'h02);
    checkPins(8'h00);
    busWrite(FLASH_CONTROL_ADDR, 8'h00);
    armHv(8'h06, USER_BASE, 8'hff);
    checkPins(8'h07);
    waitSweep();
    busWrite(FLASH_CONTROL_ADDR, 8'h00);
    checkPins(8'h00);
    busRead(USER_BASE, ERASED_BYTE);
    busRead(USER_LAST, ERASED_BYTE);
    busRead(16'hffff, ERASED_BYTE);
    armHv(8'h01, 16'hdc3f, 8'hff);
    checkPins(8'h06);
    busWrite(16'hdc3f, 8'h5a);
    busWrite(16'hdc40, 8'h3c);
    busWrite(16'hdc40, 8'hf0);
    busWrite(16'hdc80, 8'h11);
    busWrite(FLASH_CONTROL_ADDR, 8'h00);
    busRead(16'hdc40, 8'h30);
    armHv(8'h02, 16'hdc40, 8'hff);
    checkPins(8'h07);
    waitSweep();
    busWrite(FLASH_CONTROL_ADDR, 8'h00);
    busRead(16'hdc3f, 8'h5a);
    busRead(16'hdc40, ERASED_BYTE);
    busRead(16'hdc80, 8'h11);
    @(posedge clk);
    externalView <= 1'b1;
    busRead(16'hdc3f, BLOCKED_READ);
    @(posedge clk);
    externalView <= 1'b0;
    // Skipping the boundary read must leave high voltage refused
    busWrite(FLASH_CONTROL_ADDR, 8'h01);
    busWrite(16'hdc80, 8'h00);
    repeat (NVS_CYCLES) @(posedge clk);
    busWrite(FLASH_CONTROL_ADDR, 8'h09);
    busRead(FLASH_CONTROL_ADDR, 8'h01);
    checkPins(8'h00);
    busWrite(FLASH_CONTROL_ADDR, 8'h00);
    busWrite(PROTECT_BOUNDARY_ADDR, 8'hfe);
    busWrite(PROTECT_BOUNDARY_ADDR, 8'hff);
    busRead(PROTECT_BOUNDARY_ADDR, 8'hfe);
    armHv(8'h01, VECT_BASE, 8'hfe);
    checkPins(8'h00);
    busRead(FLASH_CONTROL_ADDR, 8'h01);
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
